// ---- design/fctd_pkg.sv ----
`default_nettype none
package fctd_pkg;
	localparam int          FCTD_SEQ_DIVIDEND_W = 14;
	localparam int          FCTD_SEQ_DIVISOR_W  = 11;
	localparam int          FCTD_SEQ_QUOT_W     = 5;
	localparam int          FCTD_SEQ_REST_W     = 10;
	localparam int          FCTD_SLOT_DIVIDEND_W = 10;
	localparam int          FCTD_SLOT_QUOT_W    = 5;
	localparam int          FCTD_SLOT_REST_W    = 2;
	localparam logic [9:0]  FCTD_SLOT_DIVISOR   = 10'h020;
	localparam int          FCTD_UPD_SEQ_BIT    = 1;
	localparam logic [15:0] FCTD_FC_TIMING_FIRST = 16'h1000;
	localparam logic [15:0] FCTD_FC_TIMING_LAST  = 16'h100D;

	typedef struct packed {
		logic [FCTD_SEQ_QUOT_W-1:0]  seq_quot;
		logic [FCTD_SEQ_REST_W-1:0]  seq_rest;
		logic                        seq_done;
		logic [FCTD_SLOT_QUOT_W-1:0] slot_quot;
	} fctd_result_t;
endpackage : fctd_pkg
`default_nettype wire

// ---- design/fctd_top.sv ----
`default_nettype none

// ---------------------------------------------------------------
// restoring divider
// ---------------------------------------------------------------
module fctd_div
	import fctd_pkg::*;
#(
	parameter int DW = 14,
	parameter int QW = 5,
	parameter int RW = 10
) (
	input  wire logic          ref_clk_i,
	input  wire logic          rst_n_i,
	input  wire logic          start_i,
	input  wire logic [DW-1:0] dividend_i,
	input  wire logic [DW-1:0] divisor_i,
	output logic      [QW-1:0] quot_o,
	output logic      [RW-1:0] rest_o,
	output logic               done_o
);
	localparam int CW = $clog2(DW + 1);
	if (QW > DW || RW > DW || DW < 2) begin : g_bad_widths
		$error("fctd_div: bad widths");
	end

	typedef struct packed {
		logic          busy;
		logic [CW-1:0] cnt;
		logic [DW-1:0] rem;
		logic [DW-1:0] quo;
		logic [DW-1:0] dvs;
		logic          fin;
		logic [QW-1:0] quot;
		logic [RW-1:0] rest;
		logic          done;
	} fctd_div_st_t;

	fctd_div_st_t st_r;
	fctd_div_st_t st_nxt;
	logic [DW:0]  trial;

	// ---------------------------------------------------------------
	// division step
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.fin = 1'b0;
		trial = {st_r.rem, st_r.quo[DW-1]} - {1'b0, st_r.dvs};
		if (!st_r.busy && start_i) begin
			st_nxt.busy = 1'b1;
			st_nxt.cnt  = CW'(DW);
			st_nxt.rem  = '0;
			st_nxt.quo  = dividend_i;
			st_nxt.dvs  = divisor_i;
		end else if (st_r.busy) begin
			if (trial[DW]) begin
				st_nxt.rem = {st_r.rem[DW-2:0], st_r.quo[DW-1]};
				st_nxt.quo = {st_r.quo[DW-2:0], 1'b0};
			end else begin
				st_nxt.rem = trial[DW-1:0];
				st_nxt.quo = {st_r.quo[DW-2:0], 1'b1};
			end
			st_nxt.cnt = st_r.cnt - CW'(1);
			if (st_r.cnt == CW'(1)) begin
				st_nxt.busy = 1'b0;
				st_nxt.fin  = 1'b1;
			end
		end
		if (st_r.fin) begin
			st_nxt.quot = st_r.quo[QW-1:0];
			st_nxt.rest = st_r.rem[RW-1:0];
		end
		st_nxt.done = st_r.fin;
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign quot_o = st_r.quot;
	assign rest_o = st_r.rest;
	assign done_o = st_r.done;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	a_done_copy: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		1'b1 |=> done_o == $past(st_r.fin))
		else $error("done not a copy of completion");
	a_single_done: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		done_o |=> !done_o)
		else $error("done held longer than one cycle");
	a_fixed_latency: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(!st_r.busy && start_i) |=> st_r.busy && st_r.cnt == CW'(DW))
		else $error("division not loaded with full count");
	a_count_down: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		st_r.busy && st_r.cnt != CW'(1)
			|=> st_r.busy && st_r.cnt == $past(st_r.cnt) - CW'(1))
		else $error("busy count did not step down");
	a_finish_once: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		st_r.busy && st_r.cnt == CW'(1) |=> st_r.fin && !st_r.busy)
		else $error("division did not finish on last step");
	a_hold_result: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		!st_r.fin |=> $stable(quot_o) && $stable(rest_o))
		else $error("result changed without completion");
	a_quot_capture: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		st_r.fin |=> quot_o == $past(st_r.quo[QW-1:0]) && rest_o == $past(st_r.rem[RW-1:0]))
		else $error("result not captured at completion");
	a_result_ok: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		st_r.fin && st_r.dvs != '0 |-> st_r.rem < st_r.dvs)
		else $error("leftover not below divisor");
endmodule : fctd_div

// ---------------------------------------------------------------
// timing divider chain
// ---------------------------------------------------------------
module fctd_top
	import fctd_pkg::*;
(
	input  wire logic                        ref_clk_i,
	input  wire logic                        rst_n_i,
	input  wire logic [1:0]                  upd_pulse_i,
	input  wire logic [FCTD_SEQ_DIVIDEND_W-1:0] htotal_minus_ctrl_i,
	input  wire logic [FCTD_SEQ_DIVISOR_W-1:0]  ctrl_plus_data_i,
	input  wire logic                        slot_stage_done_i,
	input  wire logic [FCTD_SLOT_DIVIDEND_W-1:0] blank_leftover_i,
	output fctd_result_t                     result_o
);
	typedef struct packed {
		fctd_result_t res;
	} fctd_top_st_t;

	fctd_top_st_t st_r;
	fctd_top_st_t st_nxt;
	logic [FCTD_SEQ_QUOT_W-1:0]  seq_quot;
	logic [FCTD_SEQ_REST_W-1:0]  seq_rest;
	logic                        seq_done;
	logic [FCTD_SLOT_QUOT_W-1:0] slot_quot;

	fctd_div #(.DW(FCTD_SEQ_DIVIDEND_W), .QW(FCTD_SEQ_QUOT_W), .RW(FCTD_SEQ_REST_W)) u_seq (
		.ref_clk_i  (ref_clk_i),
		.rst_n_i    (rst_n_i),
		.start_i    (upd_pulse_i[FCTD_UPD_SEQ_BIT]),
		.dividend_i (htotal_minus_ctrl_i),
		.divisor_i  ({3'h0, ctrl_plus_data_i}),
		.quot_o     (seq_quot),
		.rest_o     (seq_rest),
		.done_o     (seq_done)
	);

	fctd_div #(.DW(FCTD_SLOT_DIVIDEND_W), .QW(FCTD_SLOT_QUOT_W), .RW(FCTD_SLOT_REST_W)) u_slot (
		.ref_clk_i  (ref_clk_i),
		.rst_n_i    (rst_n_i),
		.start_i    (slot_stage_done_i),
		.dividend_i (blank_leftover_i),
		.divisor_i  (FCTD_SLOT_DIVISOR),
		.quot_o     (slot_quot),
		.rest_o     (),
		.done_o     ()
	);

	// ---------------------------------------------------------------
	// result register
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.res.seq_quot  = seq_quot;
		st_nxt.res.seq_rest  = seq_rest;
		st_nxt.res.seq_done  = seq_done;
		st_nxt.res.slot_quot = slot_quot;
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign result_o = st_r.res;

	a_seq_forward: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		1'b1 |=> result_o.seq_quot == $past(seq_quot))
		else $error("sequence count not forwarded");
	a_slot_forward: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		1'b1 |=> result_o.slot_quot == $past(slot_quot))
		else $error("slot count not forwarded");
	a_rest_forward: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		1'b1 |=> result_o.seq_rest == $past(seq_rest))
		else $error("sequence leftover not forwarded");
	a_done_forward: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		1'b1 |=> result_o.seq_done == $past(seq_done))
		else $error("sequence done not forwarded");
	a_done_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		result_o.seq_done |=> !result_o.seq_done)
		else $error("sequence done longer than one cycle");
	a_upd_start: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		upd_pulse_i[FCTD_UPD_SEQ_BIT] && !u_seq.st_r.busy |=> u_seq.st_r.busy)
		else $error("update pulse did not start divider");
	a_slot_start: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		slot_stage_done_i && !u_slot.st_r.busy |=> u_slot.st_r.busy)
		else $error("stage done did not start slot divider");
	a_reset_zero: assert property (@(posedge ref_clk_i)
		!rst_n_i |-> result_o == '0)
		else $error("outputs not zero in reset");
endmodule : fctd_top
`default_nettype wire

// ---- tb/fctd_tb_top.sv ----
`default_nettype none
module frame_composer_timing_divider_tb_top
	import fctd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic         ref_clk_i = 1'b0;
	logic         rst_n_i   = 1'b1;
	logic [1:0]   upd       = 2'h0;
	logic [13:0]  dvd       = 14'h0000;
	logic [10:0]  dvs       = 11'h000;
	logic         sgo       = 1'b0;
	logic [9:0]   blk       = 10'h000;
	fctd_result_t res;
	int           err_total = 0;
	int           comparisons = 0;
	int           n;

	fctd_top uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .upd_pulse_i(upd),
		.htotal_minus_ctrl_i(dvd), .ctrl_plus_data_i(dvs), .slot_stage_done_i(sgo),
		.blank_leftover_i(blk), .result_o(res));

	initial begin
		forever #4 ref_clk_i = ~ref_clk_i;
	end

	task automatic cmp(input logic [20:0] e, input logic [20:0] g);
		comparisons++;
		if (e !== g) begin
			err_total++;
			$display("Error t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : cmp

	task automatic tick(input int k);
		repeat (k) @(negedge ref_clk_i);
	endtask : tick

	// one update pulse upd = p, held across one rising edge; only bit 1 of p starts the sequence divider
	task automatic go(input logic [1:0] p, input logic [13:0] a, input logic [10:0] b);
		upd = p;
		dvd = a;
		dvs = b;
		tick(1);
		upd = 2'h0;
	endtask : go

	// bounded wait for the sequence done flag, 30 means none seen
	task automatic wait_done();
		n = 0;
		while (res.seq_done !== 1'b1 && n < 30) begin
			tick(1);
			n++;
		end
	endtask : wait_done

	task automatic t_seq();
		go(2'h2, 14'h03E8, 11'h046);
		wait_done();
		cmp(21'(n < 30), 21'h1);
		cmp(21'({res.seq_quot, res.seq_rest}), 21'({5'h0E, 10'h014}));
		tick(1);
		cmp(21'(res.seq_done), 21'h0);
		tick(5);
		cmp(21'({res.seq_quot, res.seq_rest}), 21'({5'h0E, 10'h014}));
		go(2'h1, 14'h0064, 11'h00A);
		wait_done();
		cmp(21'(n), 21'h1E);
	endtask : t_seq

	task automatic t_busy();
		go(2'h2, 14'h3FFF, 11'h7FF);
		tick(3);
		go(2'h2, 14'h0064, 11'h00A);
		wait_done();
		cmp(21'({res.seq_quot, res.seq_rest}), 21'({5'h08, 10'h007}));
		tick(1);
		wait_done();
		cmp(21'(n), 21'h1E);
	endtask : t_busy

	task automatic t_slot(input logic [9:0] v, input logic [4:0] q);
		blk = v;
		sgo = 1'b1;
		tick(1);
		sgo = 1'b0;
		tick(14);
		cmp(21'(res.slot_quot), 21'(q));
	endtask : t_slot

	task automatic t_rep();
		go(2'h2, 14'h0064, 11'h00A);
		wait_done();
		cmp(21'(res.seq_quot), 21'h0A);
		repeat (3) begin
			tick(1);
			go(2'h2, 14'h0320, 11'h032);
			wait_done();
			cmp(21'({res.seq_quot, res.seq_rest}), 21'({5'h10, 10'h000}));
		end
	endtask : t_rep

	// reset lands inside a running division, then the write sequence is repeated
	task automatic t_rst();
		go(2'h2, 14'h0320, 11'h032);
		tick(3);
		rst_n_i = 1'b0;
		#1;
		cmp(res, 21'h0);
		tick(2);
		rst_n_i = 1'b1;
		tick(1);
		cmp(res, 21'h0);
		wait_done();
		cmp(21'(n), 21'h1E);
		repeat (3) begin
			go(2'h2, 14'h03E8, 11'h046);
			wait_done();
			tick(1);
		end
		cmp(21'({res.seq_quot, res.seq_rest}), 21'({5'h0E, 10'h014}));
	endtask : t_rst

	task automatic tally_and_finish();
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		tick(1);
		rst_n_i = 1'b0;
		tick(5);
		rst_n_i = 1'b1;
		tick(1);
		cmp(res, 21'h0);
		t_seq();
		t_busy();
		t_slot(10'h064, 5'h03);
		t_slot(10'h3FF, 5'h1F);
		t_rep();
		t_rst();
		t_seq();
		tally_and_finish();
	end

	initial begin
		#20000;
		err_total++;
		tally_and_finish();
	end
endmodule : frame_composer_timing_divider_tb_top
`default_nettype wire
